// ==== fbsi_pkg.sv ====
// Constants shared by both ends of the flash bus slave interface
package fbsi_pkg;
  // ==========================================================
  // Array geometry
  localparam int unsigned ARRAY_WORDS     = 98304;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned ADDR_LO_W       = 17;
  localparam int unsigned NUM_BLOCKS      = 8;
  localparam int unsigned MAX_ERASE_BLKS  = 4;
  localparam logic [16:0] BLOCK_BASE [NUM_BLOCKS] = '{
    17'h00000, 17'h04000, 17'h08000, 17'h0c000,
    17'h10000, 17'h13000, 17'h16000, 17'h17000};
  localparam logic [16:0] ARRAY_LAST_HW   = 17'h17fff;

  // ==========================================================
  // Memory map seen by the decoder
  localparam logic [31:0] REG_WIN_FIRST   = 32'h09000200;
  localparam logic [31:0] REG_WIN_LAST    = 32'h090002ff;
  localparam logic [31:0] ARRAY_BASE      = 32'h00000000;
  localparam logic [31:0] ARRAY_LAST      = 32'h0002ffff;

  // ==========================================================
  // Register offsets (low address bits) and reset values
  localparam logic [16:0] OFS_WAIT        = 17'h00200;
  localparam logic [16:0] OFS_ADDR        = 17'h00204;
  localparam logic [16:0] OFS_DATA        = 17'h00208;
  localparam logic [16:0] OFS_CTRL        = 17'h0020c;
  localparam logic [16:0] OFS_ERASE       = 17'h00210;
  localparam logic [7:0]  RST_WAIT        = 8'h0f;
  localparam logic [16:0] RST_ADDR        = 17'h00000;
  localparam logic [15:0] RST_DATA        = 16'hffff;
  localparam logic [7:0]  RST_CTRL        = 8'h00;
  localparam logic [7:0]  RST_ERASE       = 8'h00;

  // ==========================================================
  // Transfer size and mode pin codes
  typedef enum logic [1:0] {
    FBSI_BYTE = 2'h0,
    FBSI_HALF = 2'h1,
    FBSI_WORD = 2'h2
  } fbsi_size_t;
  localparam logic [2:0] MODE_EXT8        = 3'h2;
  localparam logic [2:0] MODE_EXT16       = 3'h3;
  localparam logic [2:0] MODE_FBOOT_EXT16 = 3'h4;
  localparam logic [2:0] MODE_FBOOT_SC    = 3'h5;
  localparam logic [2:0] MODE_SBOOT_EXT16 = 3'h6;
  localparam logic [2:0] MODE_SBOOT_SC    = 3'h7;
endpackage : fbsi_pkg

// ==== fbsi_bus_if.sv ====
// Bus between the flash slave and its master/decoder
`timescale 1ns/1ps
interface fbsi_bus_if;
  logic        btrans;
  logic [31:0] ba;
  logic        bwrite;
  logic [1:0]  bsize;
  logic        flash_reg_select;
  logic        flash_array_select;
  logic [31:0] bd_m_out;
  logic        bd_m_oe;
  logic [31:0] bd_s_out;
  logic        bd_s_oe;
  logic [31:0] bd;
  logic        bwait;
  logic        berror;
  logic        blast;
  logic        bdone;

  // Wire level of the shared data bus; idle bus reads as zero
  assign bd = bd_s_oe ? bd_s_out : (bd_m_oe ? bd_m_out : 32'h00000000);

  modport master (
    output btrans, ba, bwrite, bsize, flash_reg_select,
           flash_array_select, bd_m_out, bd_m_oe,
    input  bd, bwait, berror, blast, bdone
  );
  modport slave (
    input  btrans, ba, bwrite, bsize, flash_reg_select,
           flash_array_select, bd,
    output bd_s_out, bd_s_oe, bwait, berror, blast, bdone
  );
endinterface : fbsi_bus_if

// ==== fbsi_flash_slave.sv ====
// Flash array and control register slave end of the bus
`timescale 1ns/1ps
module fbsi_flash_slave (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // System bus
  fbsi_bus_if.slave             bus,
  // Flash array side
  output logic [16:0]           array_address_bits_out,
  input  wire logic [15:0]      array_rdata_in,
  output logic [7:0]            ctrl_out,
  output logic [7:0]            erase_blocks_out,
  output logic [16:0]           hold_addr_out,
  output logic [15:0]           hold_data_out,
  output logic [7:0]            read_wait_count_out,
  // Mode pins and decoded modes
  input  wire logic [2:0]       boot_mode_pins_in,
  output logic                  ext8_bus_mode_out,
  output logic                  ext16_bus_mode_out,
  output logic                  flash_boot_ext16_mode_out,
  output logic                  flash_boot_single_chip_mode_out,
  output logic                  serial_boot_ext16_mode_out,
  output logic                  serial_boot_single_chip_mode_out
);
  import fbsi_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARR  = 3'b010,
    ST_DONE = 3'b100
  } fbsi_state_t;

  fbsi_state_t  state_ff;
  logic [7:0]   cnt_ff;
  logic         piece_ff;
  logic [15:0]  low_half_ff;
  logic [1:0]   size_ff;
  logic         byte_hi_ff;
  logic [7:0]   wait_ff;
  logic [16:0]  addr_ff;
  logic [15:0]  data_ff;
  logic [7:0]   ctrl_ff;
  logic [7:0]   erase_ff;
  logic [16:0]  arr_addr_ff;
  logic [31:0]  rdata_ff;
  logic         oe_ff;
  logic         bwait_ff;
  logic         berror_ff;
  logic         blast_ff;
  logic         done_ff;
  logic [5:0]   mode_ff;

  // ==========================================================
  // Request decode
  logic        take_reg;
  logic        take_arr;
  logic [16:0] hw_idx;
  logic        arr_bad;
  logic        reg_hit;
  logic        reg_bad;
  logic [15:0] reg_rd;
  logic [3:0]  erase_cnt;
  logic [31:0] half_rd;

  assign take_reg = state_ff == ST_IDLE && bus.btrans
                    && bus.flash_reg_select;
  assign take_arr = state_ff == ST_IDLE && bus.btrans
                    && bus.flash_array_select
                    && !bus.flash_reg_select;
  assign hw_idx   = bus.ba[17:1];
  // Array is read-only on the bus; program goes via holding regs
  assign arr_bad  = bus.bwrite || hw_idx > ARRAY_LAST_HW
                    || bus.bsize == 2'h3;

  always_comb begin
    erase_cnt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      erase_cnt = erase_cnt + {3'h0, bus.bd[i]};
    end
  end

  always_comb begin
    reg_hit = 1'b1;
    reg_rd  = 16'h0000;
    case (bus.ba[16:0])
      OFS_WAIT:  reg_rd = {8'h00, wait_ff};
      OFS_ADDR:  reg_rd = addr_ff[16:1];
      OFS_DATA:  reg_rd = data_ff;
      OFS_CTRL:  reg_rd = {8'h00, ctrl_ff};
      OFS_ERASE: reg_rd = {8'h00, erase_ff};
      default:   reg_hit = 1'b0;
    endcase
  end
  // Erase of more than four blocks at once is refused
  assign reg_bad = !reg_hit || (bus.bwrite && bus.ba[16:0] == OFS_ERASE
                   && erase_cnt > 4'(MAX_ERASE_BLKS));

  // Halfword from the array copied to both halves; a byte read repeats the addressed byte on all four lanes
  always_comb begin
    half_rd = {array_rdata_in, array_rdata_in};
    if (size_ff == FBSI_BYTE) begin
      half_rd = byte_hi_ff ? {4{array_rdata_in[15:8]}}
                           : {4{array_rdata_in[7:0]}};
    end
  end

  // ==========================================================
  // Transfer sequencing
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= 8'h00;
      piece_ff    <= 1'b0;
      low_half_ff <= 16'h0000;
      size_ff     <= 2'h0;
      byte_hi_ff  <= 1'b0;
      arr_addr_ff <= 17'h00000;
      rdata_ff    <= 32'h00000000;
      oe_ff       <= 1'b0;
      bwait_ff    <= 1'b0;
      berror_ff   <= 1'b0;
      blast_ff    <= 1'b1;
      done_ff     <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take_reg) begin
            state_ff  <= ST_DONE;
            done_ff   <= 1'b1;
            berror_ff <= reg_bad;
            blast_ff  <= 1'b1;
            rdata_ff  <= {16'h0000, reg_rd};
            oe_ff     <= !bus.bwrite;
          end else if (take_arr && arr_bad) begin
            state_ff  <= ST_DONE;
            done_ff   <= 1'b1;
            berror_ff <= 1'b1;
            blast_ff  <= 1'b1;
          end else if (take_arr) begin
            state_ff    <= ST_ARR;
            bwait_ff    <= 1'b1;
            cnt_ff      <= wait_ff;
            piece_ff    <= 1'b0;
            size_ff     <= bus.bsize;
            byte_hi_ff  <= bus.ba[0];
            // Straight from the bus, not the holding register
            arr_addr_ff <= bus.bsize == FBSI_WORD
                           ? {hw_idx[16:1], 1'b0} : hw_idx;
          end
        end
        ST_ARR: begin
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else if (size_ff == FBSI_WORD && !piece_ff) begin
            // Word read is two halfword pieces, low first
            piece_ff    <= 1'b1;
            low_half_ff <= array_rdata_in;
            cnt_ff      <= wait_ff;
            arr_addr_ff <= arr_addr_ff + 17'h00001;
          end else begin
            state_ff  <= ST_DONE;
            bwait_ff  <= 1'b0;
            done_ff   <= 1'b1;
            berror_ff <= 1'b0;
            oe_ff     <= 1'b1;
            // Burst allowed while the next halfword is in the array
            blast_ff  <= arr_addr_ff >= ARRAY_LAST_HW;
            rdata_ff  <= size_ff == FBSI_WORD
                         ? {array_rdata_in, low_half_ff} : half_rd;
          end
        end
        ST_DONE: begin
          state_ff  <= ST_IDLE;
          done_ff   <= 1'b0;
          oe_ff     <= 1'b0;
          berror_ff <= 1'b0;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wait_ff  <= RST_WAIT;
      addr_ff  <= RST_ADDR;
      data_ff  <= RST_DATA;
      ctrl_ff  <= RST_CTRL;
      erase_ff <= RST_ERASE;
    end else if (take_reg && bus.bwrite && !reg_bad) begin
      case (bus.ba[16:0])
        OFS_WAIT:  wait_ff  <= bus.bd[7:0];
        OFS_ADDR:  addr_ff  <= bus.bd[16:0];
        OFS_DATA:  data_ff  <= bus.bd[15:0];
        OFS_CTRL:  ctrl_ff  <= bus.bd[7:0];
        OFS_ERASE: erase_ff <= bus.bd[7:0];
        default:   ctrl_ff  <= ctrl_ff;
      endcase
    end
  end

  // ==========================================================
  // Mode pins decoded into flops, so every mode output is registered
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mode_ff <= 6'h00;
    end else begin
      mode_ff[0] <= boot_mode_pins_in == MODE_EXT8;
      mode_ff[1] <= boot_mode_pins_in == MODE_EXT16;
      mode_ff[2] <= boot_mode_pins_in == MODE_FBOOT_EXT16;
      mode_ff[3] <= boot_mode_pins_in == MODE_FBOOT_SC;
      mode_ff[4] <= boot_mode_pins_in == MODE_SBOOT_EXT16;
      mode_ff[5] <= boot_mode_pins_in == MODE_SBOOT_SC;
    end
  end

  assign ext8_bus_mode_out                = mode_ff[0];
  assign ext16_bus_mode_out               = mode_ff[1];
  assign flash_boot_ext16_mode_out        = mode_ff[2];
  assign flash_boot_single_chip_mode_out  = mode_ff[3];
  assign serial_boot_ext16_mode_out       = mode_ff[4];
  assign serial_boot_single_chip_mode_out = mode_ff[5];

  assign array_address_bits_out = arr_addr_ff;
  assign ctrl_out               = ctrl_ff;
  assign erase_blocks_out       = erase_ff;
  assign hold_addr_out          = addr_ff;
  assign hold_data_out          = data_ff;
  assign read_wait_count_out    = wait_ff;
  assign bus.bd_s_out           = rdata_ff;
  assign bus.bd_s_oe            = oe_ff;
  assign bus.bwait              = bwait_ff;
  assign bus.berror             = berror_ff;
  assign bus.blast              = blast_ff;
  assign bus.bdone              = done_ff;
endmodule : fbsi_flash_slave

// ==== fbsi_bus_master.sv ====
// Bus master and address decoder end facing the flash slave
`timescale 1ns/1ps
module fbsi_bus_master (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // User request
  input  wire logic        req_in,
  input  wire logic        req_write_in,
  input  wire logic [1:0]  req_size_in,
  input  wire logic [31:0] req_addr_in,
  input  wire logic [31:0] req_wdata_in,
  // User answer
  output logic             busy_out,
  output logic             done_out,
  output logic [31:0]      rdata_out,
  output logic             error_out,
  output logic             last_out,
  // System bus
  fbsi_bus_if.master       bus
);
  import fbsi_pkg::*;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_BUSY = 2'b10
  } fbsi_mstate_t;

  fbsi_mstate_t state_ff;
  logic         trans_ff;
  logic [31:0]  addr_ff;
  logic         write_ff;
  logic [1:0]   size_ff;
  logic [31:0]  wdata_ff;
  logic         wdoe_ff;
  logic         rsel_ff;
  logic         asel_ff;
  logic         done_ff;
  logic [31:0]  rdata_ff;
  logic         error_ff;
  logic         last_ff;

  // ==========================================================
  // Address decode
  logic dec_reg;
  logic dec_arr;
  assign dec_reg = req_addr_in >= REG_WIN_FIRST
                   && req_addr_in <= REG_WIN_LAST;
  assign dec_arr = req_addr_in >= ARRAY_BASE
                   && req_addr_in <= ARRAY_LAST;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_ff <= MS_IDLE;
      trans_ff <= 1'b0;
      addr_ff  <= 32'h00000000;
      write_ff <= 1'b0;
      size_ff  <= 2'h0;
      wdata_ff <= 32'h00000000;
      wdoe_ff  <= 1'b0;
      rsel_ff  <= 1'b0;
      asel_ff  <= 1'b0;
      done_ff  <= 1'b0;
      rdata_ff <= 32'h00000000;
      error_ff <= 1'b0;
      last_ff  <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        MS_IDLE: begin
          if (req_in && (dec_reg || dec_arr)) begin
            state_ff <= MS_BUSY;
            trans_ff <= 1'b1;
            addr_ff  <= req_addr_in;
            write_ff <= req_write_in;
            size_ff  <= req_size_in;
            wdata_ff <= req_wdata_in;
            wdoe_ff  <= req_write_in;
            rsel_ff  <= dec_reg;
            asel_ff  <= dec_arr;
          end else if (req_in) begin
            // Nothing decodes: answered locally as an error
            done_ff  <= 1'b1;
            error_ff <= 1'b1;
            last_ff  <= 1'b1;
          end
        end
        MS_BUSY: begin
          if (bus.bdone) begin
            state_ff <= MS_IDLE;
            trans_ff <= 1'b0;
            wdoe_ff  <= 1'b0;
            rsel_ff  <= 1'b0;
            asel_ff  <= 1'b0;
            done_ff  <= 1'b1;
            rdata_ff <= bus.bd;
            error_ff <= bus.berror;
            last_ff  <= bus.blast;
          end
        end
        default: begin
          state_ff <= MS_IDLE;
        end
      endcase
    end
  end

  assign busy_out           = trans_ff;
  assign done_out           = done_ff;
  assign rdata_out          = rdata_ff;
  assign error_out          = error_ff;
  assign last_out           = last_ff;
  assign bus.btrans         = trans_ff;
  assign bus.ba             = addr_ff;
  assign bus.bwrite         = write_ff;
  assign bus.bsize          = size_ff;
  assign bus.bd_m_out       = wdata_ff;
  assign bus.bd_m_oe        = wdoe_ff;
  assign bus.flash_reg_select   = rsel_ff;
  assign bus.flash_array_select = asel_ff;
endmodule : fbsi_bus_master

// ==== fbsi_checker.sv ====
// Bus protocol assertions beside the flash slave interface
`timescale 1ns/1ps
module fbsi_checker (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Bus signals
  input  wire logic        btrans,
  input  wire logic [31:0] ba,
  input  wire logic        bwrite,
  input  wire logic [1:0]  bsize,
  input  wire logic        flash_reg_select,
  input  wire logic        flash_array_select,
  input  wire logic        bd_s_oe,
  input  wire logic        bwait,
  input  wire logic        berror,
  input  wire logic        blast,
  input  wire logic        bdone
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic arr_sel;
  // Register select wins over array select
  assign arr_sel = btrans && flash_array_select && !flash_reg_select;

  // ==========================================================
  // Answers
  property p_reg_ans;
    $rose(btrans) && flash_reg_select |=> bdone ##1 !bdone;
  endproperty
  a_reg_ans: assert property (p_reg_ans)
    else $error("register access not answered in one cycle");
  property p_reg_bad;
    $rose(btrans) && flash_reg_select && ba[16:0] > 17'h00210
      |=> bdone && berror;
  endproperty
  a_reg_bad: assert property (p_reg_bad)
    else $error("unmapped register offset not refused");
  property p_arr_refuse;
    $rose(btrans) && arr_sel && (bwrite || bsize == 2'h3)
      |=> bdone && berror && !bwait;
  endproperty
  a_arr_refuse: assert property (p_arr_refuse)
    else $error("bad array access not refused at once");
  property p_arr_wait;
    $rose(btrans) && arr_sel && !bwrite && bsize != 2'h3
      |=> bwait && !bdone;
  endproperty
  a_arr_wait: assert property (p_arr_wait)
    else $error("array read without wait");
  property p_wait_end;
    $fell(bwait) |-> bdone;
  endproperty
  a_wait_end: assert property (p_wait_end)
    else $error("wait dropped without completion");
  // Worst case is a word read with the largest wait value
  property p_wait_bound;
    bwait |-> ##[0:520] bdone;
  endproperty
  a_wait_bound: assert property (p_wait_bound)
    else $error("array read never completes");
  property p_wait_src;
    bwait |-> arr_sel && !bwrite;
  endproperty
  a_wait_src: assert property (p_wait_src)
    else $error("wait outside an array read");

  // ==========================================================
  // Response qualifiers
  property p_err_done;
    berror |-> bdone;
  endproperty
  a_err_done: assert property (p_err_done)
    else $error("error outside a completion");
  property p_oe_read;
    bd_s_oe |-> bdone && !bwrite;
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("slave drives data outside a read completion");
  property p_idle_quiet;
    !flash_reg_select && !flash_array_select
      |-> !bd_s_oe && !bwait && !bdone;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("slave active while unselected");
  property p_last_hold;
    !bdone |-> $stable(blast);
  endproperty
  a_last_hold: assert property (p_last_hold)
    else $error("burst flag moved outside a completion");
endmodule : fbsi_checker

// ==== tb_top.sv ====
// Self-checking bench joining the bus master to the flash slave
`timescale 1ns/1ps
module tb_top;
  import fbsi_pkg::*;
  // ==========================================================
  // Signals
  logic        clk_sys_in;
  logic        rst_n_in;
  logic        req_in;
  logic        req_write_in;
  logic [1:0]  req_size_in;
  logic [31:0] req_addr_in;
  logic [31:0] req_wdata_in;
  logic        busy_out;
  logic        done_out;
  logic [31:0] rdata_out;
  logic        error_out;
  logic        last_out;
  logic [16:0] array_address_bits_out;
  logic [15:0] array_rdata_in;
  logic [7:0]  ctrl_out;
  logic [7:0]  erase_blocks_out;
  logic [16:0] hold_addr_out;
  logic [15:0] hold_data_out;
  logic [7:0]  read_wait_count_out;
  logic [2:0]  boot_mode_pins_in;
  wire  [5:0]  mode_vec;
  int          errors;
  int          checked;
  int          cycles;
  int          seed;
  int          wait_q;
  int          busy_n;
  logic [31:0] exp_q[$];

  fbsi_bus_if bus_if ();
  fbsi_bus_master u_fbsi_bus_master (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .req_in(req_in), .req_write_in(req_write_in),
    .req_size_in(req_size_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .busy_out(busy_out),
    .done_out(done_out), .rdata_out(rdata_out), .error_out(error_out),
    .last_out(last_out), .bus(bus_if));
  fbsi_flash_slave u_fbsi_flash_slave (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .bus(bus_if),
    .array_address_bits_out(array_address_bits_out),
    .array_rdata_in(array_rdata_in), .ctrl_out(ctrl_out),
    .erase_blocks_out(erase_blocks_out), .hold_addr_out(hold_addr_out),
    .hold_data_out(hold_data_out),
    .read_wait_count_out(read_wait_count_out),
    .boot_mode_pins_in(boot_mode_pins_in),
    .ext8_bus_mode_out(mode_vec[0]), .ext16_bus_mode_out(mode_vec[1]),
    .flash_boot_ext16_mode_out(mode_vec[2]),
    .flash_boot_single_chip_mode_out(mode_vec[3]),
    .serial_boot_ext16_mode_out(mode_vec[4]),
    .serial_boot_single_chip_mode_out(mode_vec[5]));
  fbsi_checker u_fbsi_checker (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .btrans(bus_if.btrans), .ba(bus_if.ba),
    .bwrite(bus_if.bwrite), .bsize(bus_if.bsize),
    .flash_reg_select(bus_if.flash_reg_select),
    .flash_array_select(bus_if.flash_array_select),
    .bd_s_oe(bus_if.bd_s_oe), .bwait(bus_if.bwait),
    .berror(bus_if.berror), .blast(bus_if.blast), .bdone(bus_if.bdone));

  // ==========================================================
  // Array contents model, a per-halfword pattern; halfwords from 0x10000 up repeat those from 0x08000 up
  function automatic logic [15:0] mem(input logic [16:0] a);
    return a[15:0] ^ {a[16], 15'h0} ^ 16'hc3a5;
  endfunction : mem
  assign array_rdata_in = mem(array_address_bits_out);

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // ==========================================================
  // Checking and bus tasks
  task automatic end_sim;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Counts edges from the request to the first edge seeing done
  task automatic xfer(input logic w, input logic [1:0] sz,
                      input logic [31:0] a, input logic [31:0] d,
                      output int n);
    n = 0;
    busy_n = 0;
    req_write_in <= w;
    req_size_in <= sz;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_in <= 1'b1;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    do begin
      @(posedge clk_sys_in);
      n++;
      if (busy_out === 1'b1)
        busy_n++;
    end while (done_out !== 1'b1 && n < 600);
  endtask : xfer

  task automatic reg_acc(input logic w, input logic [16:0] ofs,
                         input logic [31:0] d, input logic [31:0] e,
                         input logic err);
    int n;
    xfer(w, FBSI_WORD, {15'h480, ofs}, d, n);
    check(n, 3);
    check(busy_n, 2);
    check(error_out, err);
    if (!w && !err)
      check(rdata_out, e);
  endtask : reg_acc

  task automatic arr_rd(input logic [1:0] sz, input logic [31:0] a);
    int          n;
    int          e1;
    logic [16:0] i;
    logic [15:0] h;
    logic [15:0] g;
    logic [31:0] e;
    i = a[17:1];
    h = mem(i);
    g = mem(i + 17'h1);
    e1 = (wait_q < 1) ? 1 : wait_q;
    case (sz)
      FBSI_BYTE: e = {4{a[0] ? h[15:8] : h[7:0]}};
      FBSI_HALF: e = {h, h};
      default: e = {g, h};
    endcase
    exp_q.push_back(e);
    xfer(1'b0, sz, a, 32'h0, n);
    check(n, (sz == FBSI_WORD) ? 2 * e1 + 3 : e1 + 3);
    check(rdata_out, exp_q.pop_front());
    check(error_out, 1'b0);
    if (sz == FBSI_WORD)
      i = i + 17'h1;
    check(last_out, i == ARRAY_LAST_HW);
  endtask : arr_rd

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] a;
    int          n;
    seed = 32'hce5f;
    rst_n_in = 1'b0;
    req_in = 1'b0;
    req_write_in = 1'b0;
    req_size_in = 2'h0;
    req_addr_in = 32'h0;
    req_wdata_in = 32'h0;
    boot_mode_pins_in = 3'h0;
    wait_q = 15;
    for (int p = 0; p < 2; p++) begin
      repeat (3) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      check(read_wait_count_out, 32'h0f);
      reg_acc(1'b0, OFS_WAIT, 0, 32'h0f, 1'b0);
      reg_acc(1'b0, OFS_DATA, 0, 32'hffff, 1'b0);
      reg_acc(1'b0, OFS_CTRL, 0, 32'h0, 1'b0);
      reg_acc(1'b0, OFS_ERASE, 0, 32'h0, 1'b0);
      arr_rd(FBSI_HALF, 32'h100);
      reg_acc(1'b1, OFS_CTRL, 32'ha5, 0, 1'b0);
      reg_acc(1'b1, OFS_ERASE, 32'h0f, 0, 1'b0);
      reg_acc(1'b1, OFS_ERASE, 32'h1f, 0, 1'b1);
      check(erase_blocks_out, 32'h0f);
      reg_acc(1'b0, 17'h00214, 0, 0, 1'b1);
      reg_acc(1'b1, OFS_ADDR, 32'h12346, 0, 1'b0);
      check(hold_addr_out, 32'h12346);
      reg_acc(1'b0, OFS_ADDR, 0, 32'h91a3, 1'b0);
      reg_acc(1'b1, OFS_DATA, 32'h5a5a, 0, 1'b0);
      check(hold_data_out, 32'h5a5a);
      if (p == 0)
        rst_n_in <= 1'b0;
      wait_q = 15;
    end
    for (int k = 0; k < 2; k++) begin
      wait_q = 2 * k;
      reg_acc(1'b1, OFS_WAIT, wait_q, 0, 1'b0);
      check(read_wait_count_out, wait_q);
      arr_rd(FBSI_BYTE, 32'h207);
      arr_rd(FBSI_BYTE, 32'h206);
      arr_rd(FBSI_WORD, 32'h1234);
      arr_rd(FBSI_WORD, 32'h2fffc);
      arr_rd(FBSI_HALF, 32'h2fffe);
    end
    xfer(1'b1, FBSI_HALF, 32'h40, 32'h1, n);
    check({n[30:0], error_out}, 32'h7);
    xfer(1'b0, 2'h3, 32'h40, 32'h0, n);
    check({n[30:0], error_out}, 32'h7);
    xfer(1'b0, FBSI_HALF, 32'h10000000, 32'h0, n);
    check({n[30:0], error_out}, 32'h3);
    check(busy_n, 0);
    check(ctrl_out, 32'ha5);
    for (int k = 0; k < 20; k++) begin
      r = $random(seed);
      boot_mode_pins_in <= r[31:29];
      a = {14'h0, r[17:0] % 18'h30000};
      arr_rd(r[20] ? FBSI_BYTE : FBSI_HALF,
             r[20] ? a : {a[31:1], 1'b0});
    end
    for (int c = 0; c < 8; c++) begin
      boot_mode_pins_in <= 3'(c);
      repeat (3) @(posedge clk_sys_in);
      check(mode_vec, (c >= 2) ? 32'h1 << (c - 2) : 32'h0);
    end
    end_sim();
  end
endmodule : tb_top
